// file: include/rlc_pkg.sv
// constants, types and helpers shared by the reference ladder control block
package rlc_pkg;

  // register bus geometry
  localparam int unsigned AXI_ADDR_W = 4;
  localparam int unsigned AXI_DATA_W = 32;

  // register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // control register layout and reset value
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned PWR_BIT = 7;
  localparam int unsigned PIN_BIT = 6;
  localparam int unsigned RANGE_BIT = 5;
  localparam int unsigned SRC_BIT = 4;
  localparam int unsigned TAP_MSB = 3;
  localparam int unsigned TAP_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register layout
  localparam int unsigned STAT_SETTLED_BIT = 0;
  localparam int unsigned STAT_ANALOG_BIT = 1;
  localparam int unsigned STAT_DIGOE_BIT = 2;
  localparam int unsigned STAT_SLEEP_BIT = 3;
  localparam int unsigned STAT_LEVEL_LSB = 8;
  localparam int unsigned STAT_LEVEL_MSB = 15;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // level code: numerator over 96 of the source span
  localparam logic [7:0] LEVEL_DENOM = 8'h60;
  localparam logic [7:0] LOW_STEP = 8'h04;
  localparam logic [7:0] HIGH_STEP = 8'h03;
  localparam logic [7:0] HIGH_BASE = 8'h18;

  // settling wait, least time rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETTLE_NS = 10000;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 12;

  // bus channel states
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESP = 2'b01
  } rlc_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rlc_rd_state_t;

  // ideal ladder level as a numerator over LEVEL_DENOM
  function automatic logic [7:0] rlc_level(input logic range_low,
                                           input logic [3:0] tap);
    logic [7:0] tap8;
    tap8 = {4'h0, tap};
    if (range_low) begin
      rlc_level = 8'(tap8 * LOW_STEP);
    end else begin
      rlc_level = 8'(HIGH_BASE + tap8 * HIGH_STEP);
    end
  endfunction : rlc_level

endpackage : rlc_pkg

// file: design/rlc_level_calc.sv
// registered ideal output level of the reference ladder
`timescale 1ns/100ps
`default_nettype none
module rlc_level_calc
  import rlc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic power_on_i,
  input wire logic range_low_i,
  input wire logic [3:0] tap_code_i,
  output logic [7:0] level_o
);

  // level in 96ths of the span, zero while the ladder is off
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_o <= 8'h00;
    end else if (power_on_i) begin
      level_o <= rlc_level(range_low_i, tap_code_i);
    end else begin
      level_o <= 8'h00;
    end
  end

endmodule : rlc_level_calc
`default_nettype wire

// file: design/rlc_pin_ctrl.sv
// ladder output pin steering with direction override
`timescale 1ns/100ps
`default_nettype none
module rlc_pin_ctrl (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic pin_drive_i,
  input wire logic port_f_direction_i,
  output logic analog_connect_o,
  output logic digital_oe_o
);

  // pin drive wins over the direction bit; direction 0 means digital out
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      analog_connect_o <= 1'b0;
      digital_oe_o <= 1'b0;
    end else begin
      analog_connect_o <= pin_drive_i;
      digital_oe_o <= !pin_drive_i && !port_f_direction_i;
    end
  end

endmodule : rlc_pin_ctrl
`default_nettype wire

// file: design/rlc_top.sv
// reference ladder control: register file, bus slave and ladder outputs
//
// What this block does
// - bit 7 of the control register powers the ladder up when 1, down when 0.
// - bit 6 set drives the ladder level onto the output pin, clear cuts it.
// - while bit 6 is set it overrides the port direction bit of that pin.
// - bit 5 picks the low range (0 to 0.625 span) or high (0.25 to 0.719).
// - in the low range the level is tap code over 24 times the span.
// - in the high range the level is a quarter span plus tap over 32 of it.
// - bit 4 picks the external reference pair or the analog supply as span.
// - bits 3 to 0 hold the tap code 0 to 15 choosing one of 16 levels.
// - all eight bits read and write and reset to zero.
// - wake from sleep leaves the control register as it was.
// - the ladder control works apart from the comparator mode settings.
`timescale 1ns/100ps
`default_nettype none
module rlc_top
  import rlc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // device context, both from same-clock logic
  input wire logic port_f_direction_i,
  input wire logic sleep_i,
  // analog ladder macro controls
  output logic ladder_power_on_o,
  output logic ladder_pin_drive_o,
  output logic ladder_range_sel_o,
  output logic ladder_source_sel_o,
  output logic [3:0] ladder_tap_code_o,
  output logic [7:0] ladder_level_o,
  output logic ladder_output_pin_analog_o,
  output logic ladder_output_pin_digital_oe_o,
  output logic ladder_settled_o
);

  // register map, one aligned 32-bit word per register:
  //   control at byte 0x0, eight bits in wdata[7:0], upper bits read 0
  //   status at byte 0x4, read only, writes answered okay and ignored
  //   any other address answers slverr and changes nothing
  // control bits:
  //   7 power, 6 pin drive, 5 range (1 low), 4 source (1 external pair)
  //   3..0 tap code
  // status bits:
  //   0 settled, 1 pin analog, 2 pin digital oe, 3 sleep seen
  //   15..8 ideal level in 96ths of the span
  // write channel timing:
  //   address and data taken in either order or together
  //   bvalid rises at the edge that takes the later half
  //   ready is withheld until the response has been accepted
  // read channel timing:
  //   rvalid rises at the edge that takes the address
  //   arready returns at the edge that takes rready
  // level encoding:
  //   low range is four per tap step, high range 24 plus three per step
  //   zero while the ladder is powered down
  // pin steering:
  //   analog connect follows the pin drive bit
  //   digital drive only when pin drive is clear and direction is output
  // settling:
  //   any write that moves power, range, source or tap restarts the wait
  //   settled only rises while the ladder stays powered
  // sleep:
  //   sleep is reported in status only, control keeps its contents
  // hazards:
  //   a control write with byte lane 0 off is answered but changes nothing
  //   ladder controls leave from the write edge, level one edge later

  // control register and derived state
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic ctrl_we;
  logic [SETTLE_W-1:0] settle_cnt_q;
  logic settled_q;
  logic sleep_q;

  // write channel state
  rlc_wr_state_t wr_state_q;
  logic aw_held_q;
  logic w_held_q;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [AXI_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [AXI_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;

  // read channel state
  rlc_rd_state_t rd_state_q;
  logic ar_take;
  logic [AXI_DATA_W-1:0] status_word;

  // a channel is taken when its valid meets our ready
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // address and data may arrive in either order or together
  assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  assign wr_fire = (wr_state_q == WR_COLLECT) &&
                   (aw_held_q || aw_take) && (w_held_q || w_take);

  // address capture for the write channel
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
  end

  // data capture for the write channel
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // ready is offered only while that half is still missing
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= (wr_state_q == WR_COLLECT) && !wr_fire &&
                       !aw_held_q && !aw_take;
      s_axi_wready <= (wr_state_q == WR_COLLECT) && !wr_fire &&
                      !w_held_q && !w_take;
    end
  end

  // write response sequencing
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_state_q <= WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_COLLECT: begin
          if (wr_fire) begin
            wr_state_q <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            if (wr_addr == CTRL_OFFSET || wr_addr == STATUS_OFFSET) begin
              s_axi_bresp <= RESP_OKAY;
            end else begin
              s_axi_bresp <= RESP_SLVERR; // unmapped
            end
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // control write decode; only byte lane 0 carries the eight bits
  always_comb begin
    ctrl_we = 1'b0;
    ctrl_d = ctrl_q;
    if (wr_fire && wr_addr == CTRL_OFFSET && wr_strb[0]) begin
      ctrl_we = 1'b1;
      ctrl_d = wr_data[CTRL_W-1:0];
    end
  end

  // control register: cleared only by device reset, sleep never touches it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_we) begin
      ctrl_q <= ctrl_d;
    end
  end

  // static controls toward the analog ladder macro
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ladder_power_on_o <= 1'b0;
      ladder_pin_drive_o <= 1'b0;
      ladder_range_sel_o <= 1'b0;
      ladder_source_sel_o <= 1'b0;
      ladder_tap_code_o <= 4'h0;
    end else begin
      ladder_power_on_o <= ctrl_d[PWR_BIT];
      ladder_pin_drive_o <= ctrl_d[PIN_BIT];
      ladder_range_sel_o <= ctrl_d[RANGE_BIT];
      ladder_source_sel_o <= ctrl_d[SRC_BIT];
      ladder_tap_code_o <= ctrl_d[TAP_MSB:TAP_LSB];
    end
  end

  // settling wait restarts on any change that moves the output level
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_cnt_q <= '0;
      settled_q <= 1'b0;
    end else if (ctrl_we && (ctrl_d[PWR_BIT] != ctrl_q[PWR_BIT] ||
                 ctrl_d[RANGE_BIT:TAP_LSB] != ctrl_q[RANGE_BIT:TAP_LSB])) begin
      settle_cnt_q <= SETTLE_W'(SETTLE_CYCLES);
      settled_q <= 1'b0;
    end else if (settle_cnt_q != '0) begin
      settle_cnt_q <= settle_cnt_q - 1'b1;
    end else begin
      settled_q <= ctrl_q[PWR_BIT]; // level valid only while powered
    end
  end

  // registered copies for the outputs and status
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ladder_settled_o <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      ladder_settled_o <= settled_q;
      sleep_q <= sleep_i;
    end
  end

  // ideal level in 96ths of the span
  rlc_level_calc u_level (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .power_on_i(ctrl_q[PWR_BIT]),
    .range_low_i(ctrl_q[RANGE_BIT]),
    .tap_code_i(ctrl_q[TAP_MSB:TAP_LSB]),
    .level_o(ladder_level_o)
  );

  // output pin steering
  rlc_pin_ctrl u_pin (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .pin_drive_i(ctrl_q[PIN_BIT]),
    .port_f_direction_i(port_f_direction_i),
    .analog_connect_o(ladder_output_pin_analog_o),
    .digital_oe_o(ladder_output_pin_digital_oe_o)
  );

  // status word shows the block's own state
  always_comb begin
    status_word = '0;
    status_word[STAT_SETTLED_BIT] = ladder_settled_o;
    status_word[STAT_ANALOG_BIT] = ladder_output_pin_analog_o;
    status_word[STAT_DIGOE_BIT] = ladder_output_pin_digital_oe_o;
    status_word[STAT_SLEEP_BIT] = sleep_q; // powered in sleep draws current
    status_word[STAT_LEVEL_MSB:STAT_LEVEL_LSB] = ladder_level_o;
  end

  // read channel: one read under way, answer one cycle after the address
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_state_q <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          s_axi_arready <= !ar_take;
          if (ar_take) begin
            rd_state_q <= RD_RESP;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == CTRL_OFFSET) begin
              s_axi_rdata <= {24'h000000, ctrl_q};
              s_axi_rresp <= RESP_OKAY;
            end else if (s_axi_araddr == STATUS_OFFSET) begin
              s_axi_rdata <= status_word;
              s_axi_rresp <= RESP_OKAY;
            end else begin
              s_axi_rdata <= '0;
              s_axi_rresp <= RESP_SLVERR;
            end
          end
        end
        RD_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            rd_state_q <= RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
          s_axi_arready <= 1'b0;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

endmodule : rlc_top
`default_nettype wire

// file: tb/rlc_monitor.sv
// checker on the ports of the reference ladder control block
`timescale 1ns/100ps
`default_nettype none
module rlc_monitor (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic port_f_direction_i,
  input wire logic ladder_power_on_o,
  input wire logic ladder_pin_drive_o,
  input wire logic ladder_range_sel_o,
  input wire logic ladder_source_sel_o,
  input wire logic [3:0] ladder_tap_code_o,
  input wire logic [7:0] ladder_level_o,
  input wire logic ladder_output_pin_analog_o,
  input wire logic ladder_output_pin_digital_oe_o
);
  // one clock domain, checks off while reset is low
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // bus transfers taken at an edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  // control outputs move only with an accepted write
  a_ctrl_quiet: assert property ($changed({ladder_power_on_o,
    ladder_pin_drive_o, ladder_range_sel_o, ladder_source_sel_o,
    ladder_tap_code_o}) |-> $rose(s_axi_bvalid))
    else $error("control changed without write");
  a_pin_excl: assert property (!(ladder_output_pin_analog_o &&
    ladder_output_pin_digital_oe_o)) else $error("pin driven twice");
  a_pin_follow: assert property ($past(reset_n_i) |->
    ladder_output_pin_analog_o == $past(ladder_pin_drive_o) &&
    ladder_output_pin_digital_oe_o ==
    $past(!ladder_pin_drive_o && !port_f_direction_i))
    else $error("pin steering wrong");
  a_level_off: assert property ($past(reset_n_i) &&
    !$past(ladder_power_on_o) |-> ladder_level_o == 8'h00)
    else $error("level while powered down");
  a_level_low: assert property ($past(reset_n_i) &&
    $past(ladder_power_on_o) && $past(ladder_range_sel_o) |->
    ladder_level_o == {2'b00, $past(ladder_tap_code_o), 2'b00})
    else $error("low range level wrong");
  a_level_high: assert property ($past(reset_n_i) &&
    $past(ladder_power_on_o) && !$past(ladder_range_sel_o) |->
    ladder_level_o == 8'h18 + 8'h03 * $past(ladder_tap_code_o))
    else $error("high range level wrong");
endmodule : rlc_monitor
`default_nettype wire

// file: tb/rlc_top_tb.sv
// self-checking bench for the reference ladder control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module rlc_top_tb
  import rlc_pkg::*;
;
  logic clock_i, reset_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, port_f_direction_i;
  logic sleep_i, ladder_power_on_o, ladder_pin_drive_o, ladder_range_sel_o;
  logic ladder_source_sel_o, ladder_output_pin_analog_o, ladder_settled_o;
  logic ladder_output_pin_digital_oe_o;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, ladder_tap_code_o;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] ladder_level_o, ctl, exp_lvl;
  logic [33:0] expq[$];
  logic [33:0] got;
  int err_count, checks, cyc;
  wire [7:0] ctl_o = {ladder_power_on_o, ladder_pin_drive_o,
    ladder_range_sel_o, ladder_source_sel_o, ladder_tap_code_o};

  rlc_top u_rlc_top (.*);

  // 40 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // prints the verdict and ends the run
  task automatic give_verdict();
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // one write, both channels offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    expq.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock_i);
      if (s_axi_awready) aw_ok = 1'b1;
      if (s_axi_wready) w_ok = 1'b1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clock_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  // one read, expected response code and data noted first
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clock_i);
  endtask : rd

  // compares ladder outputs with a control value
  task automatic ports(input logic [7:0] c, input logic dir);
    #1;
    exp_lvl = !c[7] ? 8'h00 : c[5] ? 8'(c[3:0] * 4) : 8'(24 + c[3:0] * 3);
    `CHK(ctl_o, c)
    `CHK(ladder_level_o, exp_lvl)
    `CHK(ladder_output_pin_analog_o, c[6])
    `CHK(ladder_output_pin_digital_oe_o, !c[6] && !dir)
    @(posedge clock_i);
  endtask : ports

  // takes the oldest note whenever a response completes
  always @(posedge clock_i) begin
    if (s_axi_bvalid && s_axi_bready) begin
      got = expq.pop_front();
      `CHK({s_axi_bresp, 32'h0}, got)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      got = expq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, got)
    end
  end

  // cuts a hang short
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, sleep_i} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    port_f_direction_i = 1'b1;
    reset_n_i = 1'b0;
    ctl = 8'($urandom(52));
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    ports(8'h00, 1'b1);
    rd(CTRL_OFFSET, 34'h0);
    // single bits, every tap in both ranges, then random values
    for (int i = 0; i < 56; i++) begin
      ctl = (i < 8) ? 8'h01 << i : (i < 40) ? {2'b10, i[4], 1'b0, i[3:0]}
            : 8'($urandom);
      port_f_direction_i <= 1'($urandom);
      wr(CTRL_OFFSET, {24'($urandom), ctl}, 4'hf, RESP_OKAY);
      rd(CTRL_OFFSET, {26'h0, ctl});
      ports(ctl, port_f_direction_i);
    end
    // masked, unmapped and status writes leave control alone
    wr(CTRL_OFFSET, 32'h0, 4'h0, RESP_OKAY);
    wr(4'h8, 32'h0, 4'hf, RESP_SLVERR);
    wr(STATUS_OFFSET, 32'h0, 4'hf, RESP_OKAY);
    rd(CTRL_OFFSET, {26'h0, ctl});
    // powered low range tap 5, sleep, settling wait
    port_f_direction_i <= 1'b1;
    wr(CTRL_OFFSET, 32'ha5, 4'h1, RESP_OKAY);
    sleep_i <= 1'b1;
    repeat (450) @(posedge clock_i);
    `CHK(ladder_settled_o, 1'b1)
    rd(STATUS_OFFSET, {18'h0, 8'h14, 8'h09});
    sleep_i <= 1'b0;
    rd(CTRL_OFFSET, {26'h0, 8'ha5});
    // power cleared before sleep, contents kept through it
    wr(CTRL_OFFSET, 32'h25, 4'h1, RESP_OKAY);
    sleep_i <= 1'b1;
    rd(CTRL_OFFSET, {26'h0, 8'h25});
    sleep_i <= 1'b0;
    // second reset in mid-run clears everything
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rd(CTRL_OFFSET, 34'h0);
    ports(8'h00, 1'b1);
    give_verdict();
  end
endmodule : rlc_top_tb

bind rlc_top rlc_monitor u_rlc_monitor (.*);
`default_nettype wire
